/* mtb_pkg.sv */
// Purpose: Shared constants and types of the master time base block
// Assumes: 16-bit register port, word index addressing
// Notes: Register indices are local to this block
`default_nettype none

package mtb_pkg;

  // ==========================================================
  // Bus widths
  localparam int MTB_ADDR_W = 4;
  localparam int MTB_DATA_W = 16;

  // ==========================================================
  // Register indices
  localparam logic [3:0] MTB_REG_PRIMARY_CONTROL = 4'h0;
  localparam logic [3:0] MTB_REG_PRIMARY_CLOCK_DIVIDER = 4'h1;
  localparam logic [3:0] MTB_REG_PRIMARY_PERIOD = 4'h2;
  localparam logic [3:0] MTB_REG_PRIMARY_SPECIAL_EVENT_COMPARE = 4'h3;
  localparam logic [3:0] MTB_REG_SECONDARY_TIMEBASE_CONTROL = 4'h4;
  localparam logic [3:0] MTB_REG_SECONDARY_CLOCK_DIVIDER = 4'h5;
  localparam logic [3:0] MTB_REG_SECONDARY_PERIOD = 4'h6;
  localparam logic [3:0] MTB_REG_SECONDARY_SPECIAL_EVENT_COMPARE = 4'h7;
  localparam logic [3:0] MTB_REG_CHOP_CLOCK_GENERATOR = 4'h8;
  localparam logic [3:0] MTB_REG_MASTER_DUTY_CYCLE = 4'h9;

  // ==========================================================
  // Field positions
  localparam int MTB_ENABLE_BIT = 15;
  localparam int MTB_CHOP_EN_BIT = 15;
  localparam int MTB_CHOP_DIV_MSB = 9;
  localparam int MTB_CHOP_DIV_LSB = 3;
  localparam int MTB_CMP_LSB = 3;
  localparam int MTB_PRESC_W = 3;

  // ==========================================================
  // Reset values and codes
  localparam logic [15:0] MTB_PERIOD_RESET = 16'hFFF8;
  localparam logic [15:0] MTB_DUTY_RESET = 16'h0000;
  localparam logic [12:0] MTB_CMP_RESET = 13'h0000;
  localparam logic [2:0] MTB_PRESC_RESET = 3'h0;
  localparam logic [2:0] MTB_PRESC_RESERVED = 3'h7;
  localparam logic [2:0] MTB_SYNC_SRC_LAST = 3'h3;

  // ==========================================================
  // Secondary control register layout
  typedef struct packed {
    logic [2:0] unused;
    logic special_event_pending;
    logic special_event_irq_enable;
    logic immediate_period_update;
    logic sync_polarity_invert;
    logic sync_output_enable;
    logic external_sync_enable;
    logic [2:0] sync_source_sel;
    logic [3:0] special_event_postscale;
  } mtb_sec_ctrl_t;

  localparam mtb_sec_ctrl_t MTB_SEC_CTRL_RESET = 16'h0000;

endpackage

`default_nettype wire

/* mtb_master_time_base.sv */
// Purpose: Primary and secondary master time bases with chop clock
// Assumes: Sync inputs synchronous to clk; one register port
// Notes: Secondary pending flag is cleared by the acknowledge input
//
// Overview of operation
// - Prescaler divides by 1 to 64, default 1
// - Secondary has own independent prescaler field
// - Primary period 16-bit, resets to 0xFFF8
// - Primary compare holds bits 15-3, low zero
// - Secondary compare holds bits 15-3, low zero
// - Pending bit set by hardware, not writable
// - Enable bit gates secondary special event interrupt
// - Immediate bit chooses write-time or boundary update
// - Polarity bit inverts sync input and output
// - Sync output driven only when enabled
// - External sync restarts secondary base when enabled
// - Source field selects inputs 1 to 4
// - Postscaler passes one of N+1 events
// - Secondary period 16-bit, resets to 0xFFF8
// - Chop generator runs only when enabled
// - Chop half period is divider plus one steps
// - Chop clock driven by primary prescaler
// - Master duty 16-bit, cleared at reset
// - Duty resolution coarsens near period edges; this block passes the full value on
// - Module enable runs prescalers, counters, events and chop; registers and duty output work regardless
`default_nettype none

module mtb_master_time_base
  import mtb_pkg::*;
#(
  parameter int NUM_SYNC_IN = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [MTB_ADDR_W-1:0] addr,
  input wire logic [MTB_DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [MTB_DATA_W-1:0] rd_data,
  input wire logic [NUM_SYNC_IN-1:0] external_sync_input,
  input wire logic special_event_ack,
  output logic secondary_sync_output,
  output logic secondary_sync_output_oe,
  output logic [15:0] primary_master_counter,
  output logic [15:0] secondary_master_counter,
  output logic primary_special_event,
  output logic secondary_special_event_trigger,
  output logic secondary_special_event_irq,
  output logic chop_clock,
  output logic [15:0] master_duty_cycle
);

  // ==========================================================
  // Prescaler terminal count
  function automatic logic [5:0] presc_max(input logic [2:0] sel);
    logic [5:0] m;
    m = 6'h00;
    case (sel)
      3'h0: m = 6'h00;
      3'h1: m = 6'h01;
      3'h2: m = 6'h03;
      3'h3: m = 6'h07;
      3'h4: m = 6'h0F;
      3'h5: m = 6'h1F;
      3'h6: m = 6'h3F;
      // Reserved code falls back to divide by 1
      MTB_PRESC_RESERVED: m = 6'h00;
    endcase
    return m;
  endfunction

  // ==========================================================
  // Register storage
  logic module_enable_q;
  logic [2:0] pri_presc_q;
  logic [2:0] sec_presc_q;
  logic [15:0] pri_period_q;
  logic [15:0] sec_period_q;
  logic [12:0] pri_cmp_q;
  logic [12:0] sec_cmp_q;
  mtb_sec_ctrl_t sec_ctrl_q;
  logic special_event_pending_q;
  logic chop_generator_enable_q;
  logic [6:0] chop_div_q;
  logic [15:0] master_duty_q;
  logic [15:0] rd_data_q;

  // ==========================================================
  // Address decode
  wire wr_pctl = wr_en && (addr == MTB_REG_PRIMARY_CONTROL);
  wire wr_pdiv = wr_en && (addr == MTB_REG_PRIMARY_CLOCK_DIVIDER);
  wire wr_pper = wr_en && (addr == MTB_REG_PRIMARY_PERIOD);
  wire wr_pcmp = wr_en && (addr == MTB_REG_PRIMARY_SPECIAL_EVENT_COMPARE);
  wire wr_sctl = wr_en && (addr == MTB_REG_SECONDARY_TIMEBASE_CONTROL);
  wire wr_sdiv = wr_en && (addr == MTB_REG_SECONDARY_CLOCK_DIVIDER);
  wire wr_sper = wr_en && (addr == MTB_REG_SECONDARY_PERIOD);
  wire wr_scmp = wr_en && (addr == MTB_REG_SECONDARY_SPECIAL_EVENT_COMPARE);
  wire wr_chop = wr_en && (addr == MTB_REG_CHOP_CLOCK_GENERATOR);
  wire wr_mdc = wr_en && (addr == MTB_REG_MASTER_DUTY_CYCLE);

  // ==========================================================
  // Configuration registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      module_enable_q <= 1'b0;
      pri_presc_q <= MTB_PRESC_RESET;
      sec_presc_q <= MTB_PRESC_RESET;
      pri_period_q <= MTB_PERIOD_RESET;
      sec_period_q <= MTB_PERIOD_RESET;
      pri_cmp_q <= MTB_CMP_RESET;
      sec_cmp_q <= MTB_CMP_RESET;
      sec_ctrl_q <= MTB_SEC_CTRL_RESET;
      chop_generator_enable_q <= 1'b0;
      chop_div_q <= 7'h00;
      master_duty_q <= MTB_DUTY_RESET;
    end else begin
      if (wr_pctl) module_enable_q <= wr_data[MTB_ENABLE_BIT];
      if (wr_pdiv) pri_presc_q <= wr_data[MTB_PRESC_W-1:0];
      if (wr_sdiv) sec_presc_q <= wr_data[MTB_PRESC_W-1:0];
      if (wr_pper) pri_period_q <= wr_data;
      if (wr_sper) sec_period_q <= wr_data;
      if (wr_pcmp) pri_cmp_q <= wr_data[15:MTB_CMP_LSB];
      if (wr_scmp) sec_cmp_q <= wr_data[15:MTB_CMP_LSB];
      if (wr_sctl) begin
        // Pending and unused bits ignore software writes
        sec_ctrl_q <= {4'h0, wr_data[11:0]};
      end
      if (wr_chop) begin
        chop_generator_enable_q <= wr_data[MTB_CHOP_EN_BIT];
        chop_div_q <= wr_data[MTB_CHOP_DIV_MSB:MTB_CHOP_DIV_LSB];
      end
      if (wr_mdc) master_duty_q <= wr_data;
    end
  end

  // ==========================================================
  // Input prescalers
  logic [5:0] pri_pcnt_q;
  logic [5:0] sec_pcnt_q;
  wire pri_tick = module_enable_q && (pri_pcnt_q == presc_max(pri_presc_q));
  wire sec_tick = module_enable_q && (sec_pcnt_q == presc_max(sec_presc_q));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pri_pcnt_q <= 6'h00;
      sec_pcnt_q <= 6'h00;
    end else begin
      pri_pcnt_q <= (!module_enable_q || pri_tick) ? 6'h00 : pri_pcnt_q + 6'h01;
      sec_pcnt_q <= (!module_enable_q || sec_tick) ? 6'h00 : sec_pcnt_q + 6'h01;
    end
  end

  // ==========================================================
  // External sync selection and edge detect
  wire src_valid = (sec_ctrl_q.sync_source_sel <= MTB_SYNC_SRC_LAST);
  wire [1:0] src_idx = sec_ctrl_q.sync_source_sel[1:0];
  wire sync_raw = src_valid && external_sync_input[src_idx];
  wire sync_level = sync_raw ^ sec_ctrl_q.sync_polarity_invert;
  logic sync_level_q;
  wire sync_evt = module_enable_q && sec_ctrl_q.external_sync_enable && src_valid
                  && sync_level && !sync_level_q;

  // ==========================================================
  // Primary master counter
  logic [15:0] pri_cnt_q;
  logic [15:0] pri_per_act_q;
  wire pri_wrap = pri_tick && (pri_cnt_q >= pri_per_act_q);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pri_cnt_q <= 16'h0000;
      pri_per_act_q <= MTB_PERIOD_RESET;
    end else begin
      if (!module_enable_q) begin
        pri_cnt_q <= 16'h0000;
        pri_per_act_q <= pri_period_q;
      end else if (pri_wrap) begin
        pri_cnt_q <= 16'h0000;
        pri_per_act_q <= pri_period_q;
      end else if (pri_tick) begin
        pri_cnt_q <= pri_cnt_q + 16'h0001;
      end
    end
  end

  // ==========================================================
  // Secondary master counter
  logic [15:0] sec_cnt_q;
  logic [15:0] sec_per_act_q;
  wire sec_wrap = sec_tick && (sec_cnt_q >= sec_per_act_q);
  wire sec_boundary = sec_wrap || sync_evt;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sec_cnt_q <= 16'h0000;
      sec_per_act_q <= MTB_PERIOD_RESET;
      sync_level_q <= 1'b0;
    end else begin
      sync_level_q <= sync_level;
      if (!module_enable_q || sync_evt || sec_wrap) begin
        sec_cnt_q <= 16'h0000;
      end else if (sec_tick) begin
        sec_cnt_q <= sec_cnt_q + 16'h0001;
      end
      if (wr_sper && sec_ctrl_q.immediate_period_update) begin
        sec_per_act_q <= wr_data;
      end else if (sec_boundary || !module_enable_q) begin
        sec_per_act_q <= sec_period_q;
      end
    end
  end

  // ==========================================================
  // Special events and postscaler
  wire pri_match = pri_tick && (pri_cnt_q == {pri_cmp_q, 3'h0});
  wire sec_match = sec_tick && (sec_cnt_q == {sec_cmp_q, 3'h0});
  logic [3:0] ps_cnt_q;
  wire ps_hit = sec_match && (ps_cnt_q == sec_ctrl_q.special_event_postscale);
  logic pri_event_q;
  logic sec_trig_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ps_cnt_q <= 4'h0;
      pri_event_q <= 1'b0;
      sec_trig_q <= 1'b0;
      special_event_pending_q <= 1'b0;
    end else begin
      pri_event_q <= pri_match;
      sec_trig_q <= ps_hit;
      if (!module_enable_q || ps_hit) begin
        ps_cnt_q <= 4'h0;
      end else if (sec_match) begin
        ps_cnt_q <= ps_cnt_q + 4'h1;
      end
      // Set beats acknowledge so a back-to-back event is kept
      if (ps_hit) begin
        special_event_pending_q <= 1'b1;
      end else if (special_event_ack) begin
        special_event_pending_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Secondary sync output
  logic sync_out_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_out_q <= 1'b0;
    end else begin
      sync_out_q <= sec_boundary ^ sec_ctrl_q.sync_polarity_invert;
    end
  end

  // ==========================================================
  // Chop clock generator
  logic [6:0] chop_cnt_q;
  logic chop_q;
  wire chop_run = chop_generator_enable_q && module_enable_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chop_cnt_q <= 7'h00;
      chop_q <= 1'b0;
    end else if (!chop_run) begin
      chop_cnt_q <= 7'h00;
      chop_q <= 1'b0;
    end else if (pri_tick) begin
      // Primary prescaler drives the chop step
      if (chop_cnt_q >= chop_div_q) begin
        chop_cnt_q <= 7'h00;
        chop_q <= !chop_q;
      end else begin
        chop_cnt_q <= chop_cnt_q + 7'h01;
      end
    end
  end

  // ==========================================================
  // Read path
  wire [15:0] sec_ctrl_rd = {3'h0, special_event_pending_q, sec_ctrl_q[11:0]};
  wire [15:0] chop_rd = {chop_generator_enable_q, 5'h00, chop_div_q, 3'h0};
  wire [15:0] rd_word =
    (addr == MTB_REG_PRIMARY_CONTROL) ? {module_enable_q, 15'h0000} :
    (addr == MTB_REG_PRIMARY_CLOCK_DIVIDER) ? {13'h0000, pri_presc_q} :
    (addr == MTB_REG_PRIMARY_PERIOD) ? pri_period_q :
    (addr == MTB_REG_PRIMARY_SPECIAL_EVENT_COMPARE) ? {pri_cmp_q, 3'h0} :
    (addr == MTB_REG_SECONDARY_TIMEBASE_CONTROL) ? sec_ctrl_rd :
    (addr == MTB_REG_SECONDARY_CLOCK_DIVIDER) ? {13'h0000, sec_presc_q} :
    (addr == MTB_REG_SECONDARY_PERIOD) ? sec_period_q :
    (addr == MTB_REG_SECONDARY_SPECIAL_EVENT_COMPARE) ? {sec_cmp_q, 3'h0} :
    (addr == MTB_REG_CHOP_CLOCK_GENERATOR) ? chop_rd :
    (addr == MTB_REG_MASTER_DUTY_CYCLE) ? master_duty_q :
    16'h0000;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_q <= 16'h0000;
    end else begin
      rd_data_q <= rd_en ? rd_word : 16'h0000;
    end
  end

  // ==========================================================
  // Outputs
  assign rd_data = rd_data_q;
  assign primary_master_counter = pri_cnt_q;
  assign secondary_master_counter = sec_cnt_q;
  assign primary_special_event = pri_event_q;
  assign secondary_special_event_trigger = sec_trig_q;
  assign secondary_special_event_irq =
    special_event_pending_q && sec_ctrl_q.special_event_irq_enable;
  assign secondary_sync_output = sync_out_q;
  assign secondary_sync_output_oe = sec_ctrl_q.sync_output_enable;
  assign chop_clock = chop_q;
  // Full LSB passed on; edge coarsening happens in the generators
  assign master_duty_cycle = master_duty_q;

  // ==========================================================
  // Assertions
  property p_presc_div2;
    @(posedge clk) disable iff (!reset_n)
      (module_enable_q && pri_presc_q == 3'h1 && $stable(pri_presc_q) && pri_tick)
      |=> !pri_tick ##1 (pri_tick || !module_enable_q);
  endproperty
  a_presc_div2: assert property (p_presc_div2) else $error("divide by 2 tick spacing wrong");

  property p_pri_cmp_low;
    @(posedge clk) disable iff (!reset_n)
      (rd_en && addr == MTB_REG_PRIMARY_SPECIAL_EVENT_COMPARE) |=> (rd_data[2:0] == 3'h0);
  endproperty
  a_pri_cmp_low: assert property (p_pri_cmp_low) else $error("compare low bits not zero");

  property p_sec_cmp_low;
    @(posedge clk) disable iff (!reset_n)
      (rd_en && addr == MTB_REG_SECONDARY_SPECIAL_EVENT_COMPARE) |=> (rd_data[2:0] == 3'h0);
  endproperty
  a_sec_cmp_low: assert property (p_sec_cmp_low) else $error("secondary compare low bits set");

  property p_pending_set;
    @(posedge clk) disable iff (!reset_n)
      ps_hit |=> special_event_pending_q && secondary_special_event_trigger;
  endproperty
  a_pending_set: assert property (p_pending_set) else $error("pending not set by trigger");

  property p_irq_gate;
    @(posedge clk) disable iff (!reset_n)
      (wr_sctl && !wr_data[11]) |=> !secondary_special_event_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt not gated by enable");

  property p_immediate;
    @(posedge clk) disable iff (!reset_n)
      (wr_sper && sec_ctrl_q.immediate_period_update) |=> (sec_per_act_q == $past(wr_data));
  endproperty
  a_immediate: assert property (p_immediate) else $error("immediate period not applied");

  property p_sync_oe;
    @(posedge clk) disable iff (!reset_n)
      wr_sctl |=> (secondary_sync_output_oe == $past(wr_data[8]));
  endproperty
  a_sync_oe: assert property (p_sync_oe) else $error("sync output enable mismatch");

  property p_sync_restart;
    @(posedge clk) disable iff (!reset_n)
      sync_evt |=> (secondary_master_counter == 16'h0000);
  endproperty
  a_sync_restart: assert property (p_sync_restart) else $error("sync did not restart counter");

  property p_postscale;
    @(posedge clk) disable iff (!reset_n)
      (sec_match && !ps_hit && module_enable_q) |=> (ps_cnt_q == $past(ps_cnt_q) + 4'h1);
  endproperty
  a_postscale: assert property (p_postscale) else $error("postscaler count wrong");

  property p_chop_off;
    @(posedge clk) disable iff (!reset_n)
      !chop_run |=> !chop_clock;
  endproperty
  a_chop_off: assert property (p_chop_off) else $error("chop clock runs while disabled");

  property p_duty_write;
    @(posedge clk) disable iff (!reset_n)
      wr_mdc |=> (master_duty_cycle == $past(wr_data));
  endproperty
  a_duty_write: assert property (p_duty_write) else $error("master duty not written");

  property p_disabled_idle;
    @(posedge clk) disable iff (!reset_n)
      !module_enable_q |=> (primary_master_counter == 16'h0000) && (pri_pcnt_q == 6'h00);
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("counter runs while disabled");

  property p_pri_event;
    @(posedge clk) disable iff (!reset_n)
      pri_match |=> primary_special_event;
  endproperty
  a_pri_event: assert property (p_pri_event) else $error("primary special event missing");

  property p_sec_bound;
    @(posedge clk) disable iff (!reset_n)
      (sec_wrap && !sync_evt) |=> (secondary_master_counter == 16'h0000);
  endproperty
  a_sec_bound: assert property (p_sec_bound) else $error("secondary counter did not wrap");

endmodule

`default_nettype wire

/* mtb_sync_source.sv */
// Purpose: Far-side model of the external sync sources
// Assumes: Pulses synchronous to clk
// Notes: Selected line pulses for two cycles every INTERVAL cycles
`default_nettype none

module mtb_sync_source #(
  parameter int INTERVAL = 48
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] src,
  input wire logic pol,
  output logic [3:0] sync_out
);
  timeunit 1ns;
  timeprecision 1ns;

  int cnt;

  // ==========================================================
  // Pulse timer
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      cnt <= 0;
    else
      cnt <= (cnt == INTERVAL - 1) ? 0 : cnt + 1;
  end

  // Idle lines sit at the inactive level, so only the selected line shows an edge
  assign sync_out = {4{pol}} ^ ((cnt < 2) ? (4'h1 << src) : 4'h0);
endmodule

`default_nettype wire

/* mtb_master_time_base_tb_top.sv */
// Purpose: Self-checking bench of the master time base block
// Assumes: Register port with read data one cycle after the strobe
// Notes: Read results are queued by the driver and checked by a monitor
`default_nettype none

`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin \
  err_total++; $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end

module mtb_master_time_base_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import mtb_pkg::*;

  logic clk, reset_n, wr_en, rd_en, ack, ppol, cur_pol, rd_v, sync_o, sync_oe;
  logic pev, strg, irq, chop;
  logic [1:0] psrc;
  logic [3:0] addr, sync_in;
  logic [15:0] wr_data, rd_data, pcnt, scnt, duty, seed, m, e;
  logic [15:0] exp_q[$];
  logic [15:0] rst_v [11] = '{16'h0, 16'h0, 16'hFFF8, 16'h0, 16'h0, 16'h0, 16'hFFF8,
    16'h0, 16'h0, 16'h0, 16'h0};
  logic [15:0] msk [11] = '{16'h8000, 16'h0007, 16'hFFFF, 16'hFFF8, 16'h0FFF, 16'h0007,
    16'hFFFF, 16'hFFF8, 16'h83F8, 16'hFFFF, 16'h0000};
  int pss [3] = '{0, 1, 15};
  int err_total = 0;
  int checks_done = 0;
  int a, s, p, n, n2;

  mtb_master_time_base #(.NUM_SYNC_IN(4)) uut (.clk(clk), .reset_n(reset_n), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .external_sync_input(sync_in), .special_event_ack(ack), .secondary_sync_output(sync_o),
    .secondary_sync_output_oe(sync_oe), .primary_master_counter(pcnt),
    .secondary_master_counter(scnt), .primary_special_event(pev),
    .secondary_special_event_trigger(strg), .secondary_special_event_irq(irq),
    .chop_clock(chop), .master_duty_cycle(duty));

  mtb_sync_source #(.INTERVAL(48)) partner (.clk(clk), .reset_n(reset_n), .src(psrc),
    .pol(ppol), .sync_out(sync_in));

  // ==========================================================
  // Helpers
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  function automatic logic [15:0] sig(input int w);
    case (w)
      0: return pcnt;
      1: return scnt;
      2: return {15'h0, chop};
      3: return {15'h0, strg};
      default: return {15'h0, pev};
    endcase
  endfunction

  task automatic wr(input logic [3:0] ad, input logic [15:0] d);
    @(posedge clk);
    addr <= ad;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] ad, input logic [15:0] ex);
    @(posedge clk);
    addr <= ad;
    rd_en <= 1'b1;
    exp_q.push_back(ex);
    @(posedge clk);
    rd_en <= 1'b0;
  endtask

  // Cycles until the watched value next changes
  task automatic gap(input int w, output int c);
    logic [15:0] v;
    v = sig(w);
    c = 0;
    while (c < 1000 && sig(w) === v) begin
      @(negedge clk);
      c++;
    end
  endtask

  task automatic peak(input int w, input int cyc, output logic [15:0] mx);
    logic [15:0] prev;
    mx = sig(w);
    prev = mx;
    repeat (cyc) begin
      @(negedge clk);
      if (sig(w) > mx)
        mx = sig(w);
      if (w == 1 && sig(1) === 16'h0 && prev !== 16'h0) `CHK("sync_out", ~cur_pol, sync_o)
      prev = sig(w);
    end
  endtask

  task automatic till(input int w, input logic [15:0] v);
    int i;
    for (i = 0; i < 1000 && sig(w) !== v; i++)
      @(negedge clk);
  endtask

  task automatic wrap_up;
    if (err_total == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================
  // Clock, monitor, watchdog
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial rd_v = 1'b0;
  always @(posedge clk) begin
    if (rd_v) begin
      e = exp_q.pop_front();
      `CHK("rd_data", e, rd_data)
    end
    rd_v <= rd_en;
  end

  // Whole run needs well under 20000 cycles
  initial begin
    #5000000;
    err_total++;
    wrap_up();
  end

  // ==========================================================
  // Scenarios
  initial begin
    reset_n = 1'b0;
    {addr, wr_data, wr_en, rd_en, ack, psrc, ppol, cur_pol} = '0;
    seed = 16'h0007;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    for (a = 0; a < 11; a++)
      rd(a[3:0], rst_v[a]);
    for (a = 1; a < 11; a++) begin
      seed = lfsr(seed);
      wr(a[3:0], seed);
      rd(a[3:0], seed & msk[a]);
    end
    wr(4'h9, 16'h0009);
    @(negedge clk);
    `CHK("duty", 16'h0009, duty)
    wr(4'h4, 16'h0);
    // Code 7 is reserved and must fall back to divide by 1
    for (s = 0; s < 8; s++) begin
      wr(4'h0, 16'h0);
      wr(4'h1, s[15:0]);
      wr(4'h5, 16'(6 - s));
      wr(4'h2, 16'h0010);
      wr(4'h6, 16'h0010);
      wr(4'h0, 16'h8000);
      gap(0, n);
      gap(0, n);
      `CHK("primary tick", (s == 7) ? 1 : 1 << s, n)
      gap(1, n);
      gap(1, n);
      `CHK("secondary tick", (s == 7) ? 1 : 1 << (6 - s), n)
    end
    rd(4'h0, 16'h8000);
    wr(4'h0, 16'h0);
    wr(4'h1, 16'h0);
    wr(4'h2, 16'h0020);
    wr(4'h3, 16'h0018);
    wr(4'h0, 16'h8000);
    peak(0, 40, m);
    `CHK("primary wrap", 16'h0020, m)
    gap(4, n);
    `CHK("primary event", 16'h0019, pcnt)
    for (a = 0; a < 3; a++) begin
      wr(4'h0, 16'h0);
      wr(4'h5, 16'h0);
      wr(4'h6, 16'h0020);
      wr(4'h7, 16'h0010);
      wr(4'h4, 16'h0800 | pss[a][15:0]);
      wr(4'h0, 16'h8000);
      gap(3, n);
      gap(3, n);
      gap(3, n2);
      `CHK("postscale", (pss[a] + 1) * 33, n + n2)
    end
    @(negedge clk);
    `CHK("irq", 1'b1, irq)
    rd(4'h4, 16'h180F);
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    @(negedge clk);
    `CHK("irq cleared", 1'b0, irq)
    wr(4'h4, 16'h100F);
    rd(4'h4, 16'h000F);
    gap(3, n);
    gap(3, n);
    @(negedge clk);
    `CHK("irq masked", 1'b0, irq)
    rd(4'h4, 16'h100F);
    wr(4'h0, 16'h0);
    wr(4'h1, 16'h0001);
    wr(4'h5, 16'h0006);
    wr(4'h8, 16'h8010);
    wr(4'h0, 16'h8000);
    gap(2, n);
    gap(2, n);
    `CHK("chop half", 6, n)
    wr(4'h8, 16'h0010);
    // Chop output only clears one cycle after the enable bit lands
    repeat (2) @(negedge clk);
    peak(2, 50, m);
    `CHK("chop off", 16'h0, m)
    for (a = 0; a < 2; a++) begin
      wr(4'h0, 16'h0);
      wr(4'h5, 16'h0);
      wr(4'h4, a[0] ? 16'h0400 : 16'h0);
      wr(4'h6, 16'h0040);
      wr(4'h0, 16'h8000);
      till(1, 16'h0030);
      wr(4'h6, 16'h0020);
      peak(1, 20, m);
      `CHK("period update", a[0] ? 16'h0032 : 16'h0040, m)
    end
    for (s = 0; s < 5; s++) begin
      for (p = 0; p < 2; p++) begin
        cur_pol = p[0];
        wr(4'h0, 16'h0);
        ppol <= p[0];
        psrc <= s[1:0];
        wr(4'h6, 16'h0040);
        wr(4'h4, 16'h0180 | 16'(p << 9) | 16'(s << 4));
        wr(4'h0, 16'h8000);
        @(negedge clk);
        `CHK("sync oe", 1'b1, sync_oe)
        peak(1, 150, m);
        // Restart every 48 clocks caps the count at 47
        `CHK("sync limit", (s < 4) ? 16'h002F : 16'h0040, m)
      end
    end
    wr(4'h4, 16'h0);
    @(negedge clk);
    `CHK("sync oe off", 1'b0, sync_oe)
    cur_pol = 1'b0;
    peak(1, 150, m);
    `CHK("sync ignored", 16'h0040, m)
    wrap_up();
  end
endmodule

`default_nettype wire
